// *** bdpc_asserts.sv ***
// Port checker for the backup domain control block.
// Assumes whole-word writes and hready tied to hreadyout.
`timescale 1ns/100ps
`include "bdpc_regs.vh"
module bdpc_asserts (
   input        hclk,
   input        hresetn,
   input        hsel,
   input [31:0] haddr,
   input [1:0]  htrans,
   input        hwrite,
   input [31:0] hwdata,
   input        hready,
   input        hreadyout,
   input        hresp,
   input        bod_enabled,
   input        bod_detect,
   input        backup_higher,
   input        domain_from_backup,
   input        charge_enable,
   input        analog_bus_a_connect,
   input        domain_reset_pulse
);
   // ====
   // Control shadow, committed with the data phase
   reg       wr_reg, up_reg, ms_reg;
   reg [7:0] of_reg, ky_reg;
   reg [1:0] sl_reg;
   wire      rst_w = wr_reg && of_reg == `BDPC_RESET_OFS && hwdata[31];
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {wr_reg, up_reg, ms_reg, of_reg, ky_reg, sl_reg} <= 21'h0;
      end else begin
         up_reg <= 1'b1;
         wr_reg <= hsel & hready & htrans[1] & hwrite;
         of_reg <= haddr[7:0];
         if (wr_reg && of_reg == `BDPC_CTL_OFS)
            {ky_reg, ms_reg, sl_reg} <= {hwdata[15:8], hwdata[3], hwdata[1:0]};
         if (rst_w)
            {ky_reg, ms_reg, sl_reg} <= 11'h0;
      end
   end
   // ====
   // Properties
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence soft_s; rst_w; endsequence
   sequence pulse_s; domain_reset_pulse ##1 !domain_reset_pulse; endsequence
   chk_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   chk_resp_okay: assert property (!hresp)
      else $error("hresp not OKAY");
   chk_key_exact: assert property (up_reg |->
      charge_enable == $past(ky_reg == `BDPC_CHARGE_KEY)) else $error("charge key");
   chk_sel_main: assert property (up_reg && $past(sl_reg) == 2'h0 |->
      domain_from_backup == $past(!(bod_enabled && !bod_detect) && backup_higher))
      else $error("main select");
   chk_sel_debug: assert property (up_reg && $past(sl_reg) != 2'h0 |->
      domain_from_backup) else $error("debug select");
   chk_meas_link: assert property (up_reg |->
      analog_bus_a_connect == $past(ms_reg)) else $error("measure switch");
   chk_soft_pulse: assert property (soft_s |-> ##[1:2] pulse_s)
      else $error("no reset pulse");
   chk_pulse_cause: assert property (domain_reset_pulse |->
      $past(rst_w) || $past(rst_w, 2)) else $error("stray reset pulse");
   chk_reset_clears: assert property (soft_s |-> ##2 !charge_enable)
      else $error("charge kept");
endmodule // bdpc_asserts

bind bdpc_top bdpc_asserts bdpc_asserts_i (.*);

// *** bdpc_host.sv ***
// Register-port master standing in for firmware.
// Assumes hready is the one slave's hreadyout.
`timescale 1ns/100ps
module bdpc_host (
   input               hclk,
   input               hready,
   input        [31:0] hrdata,
   output logic        hsel,
   output logic [31:0] haddr,
   output logic [1:0]  htrans,
   output logic        hwrite,
   output logic [2:0]  hsize,
   output logic [31:0] hwdata,
   output logic        rvalid,
   output logic [31:0] rdata,
   output logic        hung
);
   // ====
   // Bus cycles
   initial {hsel, haddr, htrans, hwrite, hsize, hwdata, rvalid, rdata, hung} = '0;
   task automatic ready_wait;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 16) begin
         n++;
         @(posedge hclk);
      end
      if (n == 16) hung <= 1'b1;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= w;
      hsize  <= 3'h2;
      htrans <= 2'h2;
      ready_wait;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      ready_wait;
      rdata  <= hrdata;
      rvalid <= !w;
      // Released address and data lines never show stale values; hwrite and hsize keep theirs
      haddr  <= ~haddr;
      hwdata <= ~d;
   endtask
   always @(posedge hclk) if (rvalid) rvalid <= 1'b0;
endmodule // bdpc_host

// *** bdpc_regs.vh ***
// Register map, field positions, charge key and storage geometry of the backup domain control block.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
`ifndef BDPC_REGS_VH
`define BDPC_REGS_VH

// ==========================================================
// Register byte offsets
`define BDPC_CTL_OFS        8'h00
`define BDPC_RESET_OFS      8'h04
`define BDPC_STATUS_OFS     8'h08
`define BDPC_INT_STAT_OFS   8'h0C
`define BDPC_INT_MASK_OFS   8'h10
`define BDPC_STORE_OFS      8'h20
`define BDPC_STORE_LAST     8'h3C

// ==========================================================
// Control register fields
`define BDPC_SEL_LSB        0
`define BDPC_SEL_MSB        1
`define BDPC_MEAS_BIT       3
`define BDPC_KEY_LSB        8
`define BDPC_KEY_MSB        15
`define BDPC_CHARGE_KEY     8'h3C
`define BDPC_SEL_MAIN       2'h0

// Reset register field
`define BDPC_RESET_BIT      31

// Status register fields
`define BDPC_ST_SRC_BIT     0
`define BDPC_ST_CHG_BIT     1

// Interrupt bits
`define BDPC_IRQ_ALARM      0
`define BDPC_IRQ_SRCCHG     1
`define BDPC_IRQ_W          2

// Backup storage geometry
`define BDPC_STORE_WORDS    8
`define BDPC_STORE_AW       3

`endif

// *** bdpc_supply_sel.v ***
// Supply selector: picks the domain supply source from the select field.
// Assumes comparator and brownout inputs synchronous to hclk.
`timescale 1ns/100ps
`include "bdpc_regs.vh"

module bdpc_supply_sel (
   hclk,
   hresetn,
   supply_select,
   bod_enabled,
   bod_detect,
   backup_higher,
   use_backup
);
   input             hclk;
   input             hresetn;
   input  [1:0]      supply_select;
   input             bod_enabled;
   input             bod_detect;
   input             backup_higher;
   output            use_backup;

   wire              hclk;
   wire              hresetn;
   wire   [1:0]      supply_select;
   wire              bod_enabled;
   wire              bod_detect;
   wire              backup_higher;
   reg               use_backup;
   reg               use_backup_next;

   always @* begin
      if (supply_select == `BDPC_SEL_MAIN) begin
         if (bod_enabled && !bod_detect)
            use_backup_next = 1'b0;
         else
            use_backup_next = backup_higher;
      end else begin
         use_backup_next = 1'b1;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         use_backup <= 1'b0;
      else
         use_backup <= use_backup_next;
   end
endmodule // bdpc_supply_sel

// *** bdpc_top.v ***
// Backup domain power control: supply select, charge key, domain reset,
// measurement switch, retained storage and interrupts over AHB-Lite.
// Assumes hresetn comes only from backup-domain power loss, never system resets.
//
// Summary of operation
// - Select 0: main supply if brownout detect on and clean, else higher supply
// - Select 1, 2 or 3: always run from the backup supply
// - Charging enabled only when charge-key field written with 3C
// - Writing the reset field resets the backup domain registers
// - Measure bit puts backup supply scaled to 10 percent on analog bus A
// - 32 bytes of storage kept while backup supply is present
// - All registers reached through an AHB-Lite slave
// - Alarm match raises an interrupt toward the processor
// - System, watchdog and pin resets do not reset the domain
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`include "bdpc_regs.vh"

module bdpc_top (
   hclk,
   hresetn,
   hsel,
   haddr,
   htrans,
   hwrite,
   hsize,
   hwdata,
   hready,
   hrdata,
   hreadyout,
   hresp,
   bod_enabled,
   bod_detect,
   backup_higher,
   alarm_match,
   domain_from_backup,
   charge_enable,
   analog_bus_a_connect,
   domain_reset_pulse,
   irq
);
   input             hclk;
   input             hresetn;
   input             hsel;
   input  [31:0]     haddr;
   input  [1:0]      htrans;
   input             hwrite;
   input  [2:0]      hsize;
   input  [31:0]     hwdata;
   input             hready;
   output [31:0]     hrdata;
   output            hreadyout;
   output            hresp;
   input             bod_enabled;
   input             bod_detect;
   input             backup_higher;
   input             alarm_match;
   output            domain_from_backup;
   output            charge_enable;
   output            analog_bus_a_connect;
   output            domain_reset_pulse;
   output            irq;

   wire              hclk;
   wire              hresetn;
   wire              hsel;
   wire   [31:0]     haddr;
   wire   [1:0]      htrans;
   wire              hwrite;
   wire   [2:0]      hsize;
   wire   [31:0]     hwdata;
   wire              hready;
   reg    [31:0]     hrdata;
   wire              hreadyout;
   wire              hresp;
   wire              bod_enabled;
   wire              bod_detect;
   wire              backup_higher;
   wire              alarm_match;
   wire              domain_from_backup;
   reg               charge_enable;
   reg               analog_bus_a_connect;
   reg               domain_reset_pulse;
   reg               irq;

   // ==========================================================
   // AHB-Lite address phase capture
   reg               wr_pend_reg;
   reg    [7:0]      addr_reg;
   wire              take;

   assign take      = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
      end else if (hready) begin
         wr_pend_reg <= take && hwrite;
         if (take)
            addr_reg <= haddr[7:0];
      end
   end

   // ==========================================================
   // Register state
   reg    [1:0]      supply_select_reg;
   reg               supply_measure_enable_reg;
   reg    [7:0]      charge_key_reg;
   reg    [`BDPC_IRQ_W-1:0] int_stat_reg;
   reg    [`BDPC_IRQ_W-1:0] int_mask_reg;
   reg               src_prev_reg;
   reg               alarm_prev_reg;
   reg    [31:0]     store_mem [0:`BDPC_STORE_WORDS-1];
   reg    [`BDPC_IRQ_W-1:0] int_set;
   reg    [`BDPC_IRQ_W-1:0] int_stat_next;
   wire              use_backup;
   wire              soft_reset;
   wire              is_store;
   wire   [`BDPC_STORE_AW-1:0] store_idx;
   integer           i;

   function is_reg;
      input [7:0] a;
      input [7:0] ofs;
      begin
         is_reg = (a == ofs);
      end
   endfunction

   assign is_store   = (addr_reg >= `BDPC_STORE_OFS) && (addr_reg <= `BDPC_STORE_LAST);
   assign store_idx  = addr_reg[`BDPC_STORE_AW+1:2];
   // Reset of the domain is a firmware write only; no system reset reaches here
   assign soft_reset = wr_pend_reg && is_reg(addr_reg, `BDPC_RESET_OFS)
                       && hwdata[`BDPC_RESET_BIT];

   bdpc_supply_sel u_sel (
      .hclk          (hclk),
      .hresetn       (hresetn),
      .supply_select (supply_select_reg),
      .bod_enabled   (bod_enabled),
      .bod_detect    (bod_detect),
      .backup_higher (backup_higher),
      .use_backup    (use_backup)
   );
   assign domain_from_backup = use_backup;

   // ==========================================================
   // Control register
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         supply_select_reg         <= `BDPC_SEL_MAIN;
         supply_measure_enable_reg <= 1'b0;
         charge_key_reg            <= 8'h00;
      end else if (soft_reset) begin
         supply_select_reg         <= `BDPC_SEL_MAIN;
         supply_measure_enable_reg <= 1'b0;
         charge_key_reg            <= 8'h00;
      end else if (wr_pend_reg && is_reg(addr_reg, `BDPC_CTL_OFS)) begin
         supply_select_reg         <= hwdata[`BDPC_SEL_MSB:`BDPC_SEL_LSB];
         supply_measure_enable_reg <= hwdata[`BDPC_MEAS_BIT];
         charge_key_reg            <= hwdata[`BDPC_KEY_MSB:`BDPC_KEY_LSB];
      end
   end

   // ==========================================================
   // Outputs to the analog side
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         charge_enable        <= 1'b0;
         analog_bus_a_connect <= 1'b0;
         domain_reset_pulse   <= 1'b0;
      end else begin
         // Exact key only; a battery must never see this, firmware guards it
         charge_enable        <= (charge_key_reg == `BDPC_CHARGE_KEY);
         // Switch feeds the 1/10 divider onto the bus
         analog_bus_a_connect <= supply_measure_enable_reg;
         domain_reset_pulse   <= soft_reset;
      end
   end

   // ==========================================================
   // Interrupt status, mask and line
   always @* begin
      int_set = {`BDPC_IRQ_W{1'b0}};
      int_set[`BDPC_IRQ_ALARM]  = alarm_match && !alarm_prev_reg;
      int_set[`BDPC_IRQ_SRCCHG] = use_backup != src_prev_reg;
      int_stat_next = int_stat_reg;
      if (wr_pend_reg && is_reg(addr_reg, `BDPC_INT_STAT_OFS))
         int_stat_next = int_stat_next & ~hwdata[`BDPC_IRQ_W-1:0];
      // New event wins over a same-cycle clear
      int_stat_next = int_stat_next | int_set;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_stat_reg   <= {`BDPC_IRQ_W{1'b0}};
         int_mask_reg   <= {`BDPC_IRQ_W{1'b0}};
         src_prev_reg   <= 1'b0;
         alarm_prev_reg <= 1'b0;
         irq            <= 1'b0;
      end else begin
         src_prev_reg   <= use_backup;
         alarm_prev_reg <= alarm_match;
         if (soft_reset) begin
            int_stat_reg <= {`BDPC_IRQ_W{1'b0}};
            int_mask_reg <= {`BDPC_IRQ_W{1'b0}};
            irq          <= 1'b0;
         end else begin
            int_stat_reg <= int_stat_next;
            if (wr_pend_reg && is_reg(addr_reg, `BDPC_INT_MASK_OFS))
               int_mask_reg <= hwdata[`BDPC_IRQ_W-1:0];
            irq <= |(int_stat_next & int_mask_reg);
         end
      end
   end

   // ==========================================================
   // Retained storage, cleared only by domain loss or soft reset
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (i = 0; i < `BDPC_STORE_WORDS; i = i + 1)
            store_mem[i] <= 32'h00000000;
      end else if (soft_reset) begin
         for (i = 0; i < `BDPC_STORE_WORDS; i = i + 1)
            store_mem[i] <= 32'h00000000;
      end else if (wr_pend_reg && is_store) begin
         store_mem[store_idx] <= hwdata;
      end
   end

   // ==========================================================
   // Read data, registered at the address phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (take && !hwrite) begin
         hrdata <= 32'h00000000;
         case (haddr[7:0])
            `BDPC_CTL_OFS: begin
               hrdata[`BDPC_SEL_MSB:`BDPC_SEL_LSB] <= supply_select_reg;
               hrdata[`BDPC_MEAS_BIT]              <= supply_measure_enable_reg;
               hrdata[`BDPC_KEY_MSB:`BDPC_KEY_LSB] <= charge_key_reg;
            end
            `BDPC_STATUS_OFS: begin
               hrdata[`BDPC_ST_SRC_BIT] <= use_backup;
               hrdata[`BDPC_ST_CHG_BIT] <= charge_enable;
            end
            `BDPC_INT_STAT_OFS: hrdata[`BDPC_IRQ_W-1:0] <= int_stat_reg;
            `BDPC_INT_MASK_OFS: hrdata[`BDPC_IRQ_W-1:0] <= int_mask_reg;
            default: begin
               if (haddr[7:0] >= `BDPC_STORE_OFS && haddr[7:0] <= `BDPC_STORE_LAST)
                  hrdata <= store_mem[haddr[`BDPC_STORE_AW+1:2]];
            end
         endcase
      end
   end
endmodule // bdpc_top

// *** tb.sv ***
// Bench for the backup domain control block.
// Assumes bdpc_host as master and the checker bound in.
`timescale 1ns/100ps
`include "bdpc_regs.vh"
module tb;
   // ====
   // Signals
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        bod_enabled = 1'b0;
   logic        bod_detect = 1'b0;
   logic        backup_higher = 1'b0;
   logic        alarm_match = 1'b0;
   logic        saw_pulse = 1'b0;
   logic [31:0] seed = 32'h4BDA461C;
   logic [31:0] w;
   logic [31:0] mem [8];
   logic [31:0] exp_q [$];
   logic [7:0]  keys [5] = '{8'h3C, 8'h3D, 8'hC3, 8'h3C, 8'h00};
   int          mismatches = 0;
   int          samples_checked = 0;
   wire  [31:0] haddr, hwdata, hrdata, rdata;
   wire  [2:0]  hsize;
   wire  [1:0]  htrans;
   wire         hsel, hwrite, hreadyout, hresp, rvalid, hung, irq;
   wire         domain_from_backup, charge_enable, analog_bus_a_connect, domain_reset_pulse;
   always #5 hclk = ~hclk;
   bdpc_top bdpc_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .bod_enabled,
      .bod_detect, .backup_higher, .alarm_match, .domain_from_backup,
      .charge_enable, .analog_bus_a_connect, .domain_reset_pulse, .irq);
   bdpc_host bdpc_host_i (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .rvalid, .rdata, .hung);
   // ====
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bdpc_host_i.xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bdpc_host_i.xfer(1'b0, a, 32'h0);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
      @(negedge hclk);
   endtask
   task automatic alarm_rise;
      @(posedge hclk);
      alarm_match <= 1'b0;
      repeat (2) @(posedge hclk);
      alarm_match <= 1'b1;
      idle(3);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Read results and hang watch
   always @(posedge hclk) begin
      if (rvalid === 1'b1) chk(rdata, exp_q.pop_front());
      if (domain_reset_pulse === 1'b1) saw_pulse <= 1'b1;
      if (hung === 1'b1 || $time > 100000) begin
         mismatches++;
         summarize;
      end
   end
   // ====
   // Scenarios
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rd(`BDPC_CTL_OFS, 32'h0);
      rd(`BDPC_INT_MASK_OFS, 32'h0);
      $display("test reset done");
      foreach (keys[i]) begin
         wr(`BDPC_CTL_OFS, {16'h0, keys[i], 8'h01});
         idle(2);
         chk(charge_enable, keys[i] == `BDPC_CHARGE_KEY);
         rd(`BDPC_STATUS_OFS, {30'h0, keys[i] == `BDPC_CHARGE_KEY, 1'b1});
      end
      $display("test key done");
      for (int i = 0; i < 12; i++) begin
         w = rnd();
         @(posedge hclk);
         {bod_enabled, bod_detect, backup_higher} <= w[2:0];
         wr(`BDPC_CTL_OFS, {28'h0, w[3], 1'b0, 2'(i)});
         idle(2);
         chk(domain_from_backup, (i % 4 != 0) || (!(w[2] && !w[1]) && w[0]));
         chk(analog_bus_a_connect, w[3]);
      end
      rd(`BDPC_STATUS_OFS, 32'h1);
      $display("test supply done");
      foreach (mem[i]) begin
         mem[i] = rnd();
         wr(`BDPC_STORE_OFS + 8'(4 * i), mem[i]);
      end
      foreach (mem[i]) rd(`BDPC_STORE_OFS + 8'(4 * i), mem[i]);
      rd(8'h14, 32'h0);
      $display("test storage done");
      wr(`BDPC_INT_STAT_OFS, 32'h3);
      wr(`BDPC_INT_MASK_OFS, 32'h1);
      alarm_rise;
      chk(irq, 1'b1);
      rd(`BDPC_INT_STAT_OFS, 32'h1);
      wr(`BDPC_INT_STAT_OFS, 32'h1);
      idle(1);
      chk(irq, 1'b0);
      wr(`BDPC_INT_MASK_OFS, 32'h0);
      alarm_rise;
      chk(irq, 1'b0);
      rd(`BDPC_INT_STAT_OFS, 32'h1);
      // Leaving debug select for main supply must flag a source change
      @(posedge hclk);
      {bod_enabled, bod_detect, backup_higher} <= 3'b100;
      wr(`BDPC_CTL_OFS, 32'h0);
      idle(2);
      rd(`BDPC_INT_STAT_OFS, 32'h3);
      $display("test interrupt done");
      wr(`BDPC_CTL_OFS, 32'h3C08);
      saw_pulse = 1'b0;
      wr(`BDPC_RESET_OFS, 32'h80000000);
      idle(3);
      chk(saw_pulse, 1'b1);
      chk(charge_enable, 1'b0);
      chk(analog_bus_a_connect, 1'b0);
      rd(`BDPC_STORE_OFS, 32'h0);
      idle(2);
      $display("test soft reset done");
      summarize;
   end
endmodule // tb
